// ==== core/clk_ctrl.sv ====
// clock source selection, start-up timing, prescaler and clock output
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       ARST_N_I,
    // fuses (static, 0 means programmed) and calibration byte
    input  wire logic [3:0] CLOCK_SOURCE_SELECT_I,
    input  wire logic [1:0] STARTUP_TIME_SELECT_I,
    input  wire logic       DIVIDE_BY_EIGHT_DEFAULT_N_I,
    input  wire logic       CLOCK_OUTPUT_FUSE_N_I,
    input  wire logic [7:0] CALIBRATION_I,
    // source oscillator and watchdog oscillator ticks (asynchronous)
    input  wire logic       OSC_TICK_I,
    input  wire logic       WDT_TICK_I,
    // sleep wake-up and brown-out state
    input  wire logic       WAKE_I,
    input  wire logic       BROWNOUT_DETECTOR_OFF_I,
    // register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // system clocks and status
    output logic            CPU_RUN_O,
    output logic            SYS_TICK_O,
    output logic            SYS_CLK_O,
    output logic      [2:0] XTAL_MODE_O,
    output logic      [1:0] SOURCE_KIND_O,
    output logic            CLOCK_PIN_O,
    output logic            CLOCK_PIN_OE_O
);
    typedef enum logic [1:0] {
        ST_OSC, ST_RESET_DELAY, ST_RUN, ST_WAKE
    } su_state_t;

    fuse_t      fuse;
    reg_req_t   req;
    startup_t   su_sel;
    su_state_t  state_q;
    logic [7:0] trim_value_q;
    logic [3:0] prescale_select_q;
    logic       unlock_q;
    logic [2:0] unlock_cnt_q;
    logic [1:0] osc_sync_q;
    logic [1:0] wdt_sync_q;
    logic [1:0] wake_sync_q;
    logic       osc_prev_q;
    logic       wdt_prev_q;
    logic       wake_prev_q;
    logic       osc_edge;
    logic       wdt_edge;
    logic       wake_edge;
    logic [15:0] osc_cnt_q;
    logic [13:0] wd_cnt_q;
    logic [15:0] wake_cnt_q;
    logic       init_q;
    logic       tick;
    logic       clk_div;

    assign fuse = '{src_sel: CLOCK_SOURCE_SELECT_I,
                    startup_time_select:     STARTUP_TIME_SELECT_I,
                    div8:    ~DIVIDE_BY_EIGHT_DEFAULT_N_I,
                    clk_out: ~CLOCK_OUTPUT_FUSE_N_I};
    assign req  = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // reset delay in watchdog cycles for a two-bit code
    function automatic logic [13:0] wd_delay(input logic [1:0] code);
        unique case (code)
            2'b00:   wd_delay = WD_0MS;
            2'b01:   wd_delay = WD_4MS;
            default: wd_delay = WD_64MS;
        endcase
    endfunction : wd_delay

    // start-up table by source and start-up select
    always_comb begin
        su_sel = '{osc_cycles: SU_6CK, wd_cycles: WD_0MS, reserved: 1'b0};
        if (fuse.src_sel == SRC_LFXTAL) begin
            unique case (fuse.startup_time_select)
                2'b00: su_sel = '{SU_1KCK, WD_4MS, 1'b0};
                2'b01: su_sel = '{SU_1KCK, WD_64MS, 1'b0};
                2'b10: su_sel = '{SU_32KCK, WD_64MS, 1'b0};
                2'b11: su_sel = '{SU_32KCK, WD_64MS, 1'b1};
            endcase
        end else if (fuse.src_sel[3]) begin
            unique case ({fuse.src_sel[0], fuse.startup_time_select})
                3'b000: su_sel = '{SU_258CK + SU_14CK, WD_4MS, 1'b0};
                3'b001: su_sel = '{SU_258CK + SU_14CK, WD_64MS, 1'b0};
                3'b010: su_sel = '{SU_1KCK + SU_14CK, WD_0MS, 1'b0};
                3'b011: su_sel = '{SU_1KCK + SU_14CK, WD_4MS, 1'b0};
                3'b100: su_sel = '{SU_1KCK + SU_14CK, WD_64MS, 1'b0};
                3'b101: su_sel = '{SU_16KCK + SU_14CK, WD_0MS, 1'b0};
                3'b110: su_sel = '{SU_16KCK + SU_14CK, WD_4MS, 1'b0};
                3'b111: su_sel = '{SU_16KCK + SU_14CK, WD_64MS, 1'b0};
            endcase
        end else begin
            su_sel.osc_cycles = SU_6CK + SU_14CK;
            su_sel.wd_cycles  = wd_delay(fuse.startup_time_select);
            su_sel.reserved   = (fuse.startup_time_select == 2'b11);
        end
    end

    // two-stage synchronisers for the asynchronous oscillator ticks
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            osc_sync_q  <= 2'b00;
            wdt_sync_q  <= 2'b00;
            wake_sync_q <= 2'b00;
            osc_prev_q  <= 1'b0;
            wdt_prev_q  <= 1'b0;
            wake_prev_q <= 1'b0;
        end else begin
            osc_sync_q  <= {osc_sync_q[0], OSC_TICK_I};
            wdt_sync_q  <= {wdt_sync_q[0], WDT_TICK_I};
            wake_sync_q <= {wake_sync_q[0], WAKE_I};
            osc_prev_q  <= osc_sync_q[1];
            wdt_prev_q  <= wdt_sync_q[1];
            wake_prev_q <= wake_sync_q[1];
        end
    end
    assign osc_edge  = osc_sync_q[1] & ~osc_prev_q;
    assign wdt_edge  = wdt_sync_q[1] & ~wdt_prev_q;
    assign wake_edge = wake_sync_q[1] & ~wake_prev_q;

    // start-up sequencer: oscillator cycles, then watchdog-timed delay
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q    <= ST_OSC;
            osc_cnt_q  <= 16'h0000;
            wd_cnt_q   <= 14'h0000;
            wake_cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_OSC: begin
                    if (osc_cnt_q >= su_sel.osc_cycles && !su_sel.reserved)
                    begin
                        state_q <= ST_RESET_DELAY;
                    end else if (osc_edge) begin
                        osc_cnt_q <= osc_cnt_q + 16'h0001;
                    end
                end
                ST_RESET_DELAY: begin
                    if (wd_cnt_q >= su_sel.wd_cycles) begin
                        state_q <= ST_RUN;
                    end else if (wdt_edge) begin
                        wd_cnt_q <= wd_cnt_q + 14'h0001;
                    end
                end
                ST_RUN: begin
                    if (wake_edge && BROWNOUT_DETECTOR_OFF_I) begin
                        state_q    <= ST_WAKE;
                        wake_cnt_q <= 16'h0000;
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt_q >= 16'(BOD_SETTLE_CYC - 1)) begin
                        state_q <= ST_RUN;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // trim register loads calibration just after reset release
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            init_q       <= 1'b1;
            trim_value_q <= 8'h00;
        end else if (init_q) begin
            init_q       <= 1'b0;
            trim_value_q <= CALIBRATION_I;
        end else if (req.wr && req.addr == TRIM_OFFSET) begin
            trim_value_q <= req.wdata;
        end
    end

    // prescale register with timed unlock
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prescale_select_q <= SEL_RESET_DIV1;
            unlock_q          <= 1'b0;
            unlock_cnt_q      <= 3'h0;
        end else if (init_q) begin
            prescale_select_q <= fuse.div8 ? SEL_RESET_DIV8
                                           : SEL_RESET_DIV1;
        end else if (req.wr && req.addr == PRESCALE_OFFSET && unlock_q
                     && !req.wdata[UNLOCK_BIT]) begin
            prescale_select_q <= req.wdata[SEL_LSB +: 4];
            unlock_q          <= 1'b0;
        end else if (unlock_q) begin
            // rewriting the unlock value neither extends nor clears it
            unlock_cnt_q <= unlock_cnt_q + 3'h1;
            unlock_q     <= (unlock_cnt_q + 3'h1) < UNLOCK_WINDOW;
        end else if (req.wr && req.addr == PRESCALE_OFFSET
                     && req.wdata == 8'h80) begin
            unlock_q     <= 1'b1;
            unlock_cnt_q <= 3'h0;
        end
    end

    // reserved codes are held at divide-by-256 in the divider
    clk_prescaler u_prescaler (
        .clk_i     (CLK_I),
        .arst_n_i  (ARST_N_I),
        .sel_i     ((prescale_select_q > SEL_MAX) ? SEL_MAX
                                                  : prescale_select_q),
        .tick_o    (tick),
        .clk_div_o (clk_div)
    );

    // register read port, data one cycle after the strobe
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                TRIM_OFFSET:     RDATA_O <= trim_value_q;
                PRESCALE_OFFSET: RDATA_O <= {unlock_q, 3'b000,
                                             prescale_select_q};
                default:         RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // divided clocks, run status and clock output pin
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CPU_RUN_O      <= 1'b0;
            SYS_TICK_O     <= 1'b0;
            SYS_CLK_O      <= 1'b0;
            CLOCK_PIN_O    <= 1'b0;
            CLOCK_PIN_OE_O <= 1'b0;
        end else begin
            CPU_RUN_O      <= (state_q == ST_RUN);
            SYS_TICK_O     <= tick;
            SYS_CLK_O      <= clk_div;
            CLOCK_PIN_O    <= clk_div & fuse.clk_out
                              & (state_q == ST_RUN);
            CLOCK_PIN_OE_O <= fuse.clk_out;
        end
    end

    // oscillator mode and source kind for the analog side
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            XTAL_MODE_O   <= 3'h0;
            SOURCE_KIND_O <= 2'h0;
        end else begin
            XTAL_MODE_O   <= fuse.src_sel[3] ? fuse.src_sel[3:1]
                                             : 3'h0;
            unique case (fuse.src_sel)
                SRC_LFXTAL: SOURCE_KIND_O <= 2'h1;
                SRC_RC8M,
                SRC_RC128K,
                SRC_EXT:    SOURCE_KIND_O <= 2'h0;
                default:    SOURCE_KIND_O <= fuse.src_sel[3] ? 2'h2 : 2'h3;
            endcase
        end
    end
endmodule : clk_ctrl

// ==== core/clk_ctrl_pkg.sv ====
// constants and types for the clock source, start-up and prescaler control
package clk_ctrl_pkg;
    // register offsets
    localparam logic [7:0] TRIM_OFFSET      = 8'h31;
    localparam logic [7:0] PRESCALE_OFFSET  = 8'h26;
    // prescale register fields
    localparam int         UNLOCK_BIT       = 7;
    localparam int         SEL_LSB          = 0;
    localparam logic [3:0] SEL_RESET_DIV8   = 4'h3;
    localparam logic [3:0] SEL_RESET_DIV1   = 4'h0;
    localparam logic [3:0] SEL_MAX          = 4'h8;
    localparam logic [2:0] UNLOCK_WINDOW    = 3'h4;
    // clock source select codes
    localparam logic [3:0] SRC_EXT          = 4'h0;
    localparam logic [3:0] SRC_RC8M         = 4'h2;
    localparam logic [3:0] SRC_RC128K       = 4'h4;
    localparam logic [3:0] SRC_LFXTAL       = 4'h6;
    // crystal mode codes (upper three select bits)
    localparam logic [2:0] XM_LOW           = 3'h4;
    localparam logic [2:0] XM_MID           = 3'h5;
    localparam logic [2:0] XM_HIGH          = 3'h6;
    localparam logic [2:0] XM_TOP           = 3'h7;
    // start-up counts in source clock cycles
    localparam logic [15:0] SU_6CK          = 16'h0006;
    localparam logic [15:0] SU_258CK        = 16'h0102;
    localparam logic [15:0] SU_1KCK         = 16'h0400;
    localparam logic [15:0] SU_16KCK        = 16'h4000;
    localparam logic [15:0] SU_32KCK        = 16'h8000;
    localparam logic [15:0] SU_14CK         = 16'h000e;
    localparam logic [15:0] SU_NONE         = 16'h0000;
    // reset delays in watchdog oscillator cycles
    localparam logic [13:0] WD_0MS          = 14'h0000;
    localparam logic [13:0] WD_4MS          = 14'h0200;
    localparam logic [13:0] WD_64MS         = 14'h2000;
    // brown-out settle time on wake, at 250 MHz
    localparam int         BOD_SETTLE_US    = 60;
    localparam int         CLK_MHZ          = 250;
    localparam int         BOD_SETTLE_CYC   = BOD_SETTLE_US * CLK_MHZ;

    typedef struct packed {
        logic [3:0] src_sel;
        logic [1:0] startup_time_select;
        logic       div8;
        logic       clk_out;
    } fuse_t;

    typedef struct packed {
        logic [15:0] osc_cycles;
        logic [13:0] wd_cycles;
        logic        reserved;
    } startup_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage : clk_ctrl_pkg

// ==== core/clk_prescaler.sv ====
// glitch-free power-of-two system clock prescaler
`timescale 1ns/1ps
module clk_prescaler
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // selection
    input  wire logic [3:0] sel_i,
    // divided clock enable and level
    output logic            tick_o,
    output logic            clk_div_o
);
    logic [8:0] cnt_q;
    logic [3:0] cur_q;
    logic [3:0] pend_q;
    logic       chg_q;
    logic       wrap;
    logic [8:0] mask;

    assign mask = (9'h001 << cur_q) - 9'h001;
    assign wrap = (cnt_q & mask) == mask;
    assign tick_o = wrap;
    // the top bit of the live count is high for the second half period
    assign clk_div_o = (cur_q == 4'h0) ? 1'b1 : cnt_q[cur_q - 4'h1];

    // counter on the undivided clock; state not visible to software
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 9'h000;
        end else if (wrap) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    // switch only at the end of a whole old period, then the new one starts
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_q  <= 4'h0;
            pend_q <= 4'h0;
            chg_q  <= 1'b0;
        end else begin
            if (sel_i != pend_q) begin
                pend_q <= sel_i;
                chg_q  <= 1'b1;
            end
            if (chg_q && wrap) begin
                cur_q <= pend_q;
                chg_q <= (sel_i != pend_q);
            end
        end
    end
endmodule : clk_prescaler

// ==== tb/clk_ctrl_asserts.sv ====
// port assertions for the clock control block
`timescale 1ns/1ps
module clk_ctrl_asserts
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       ARST_N_I,
    // fuses and wake
    input wire logic [3:0] CLOCK_SOURCE_SELECT_I,
    input wire logic       CLOCK_OUTPUT_FUSE_N_I,
    input wire logic       WAKE_I,
    input wire logic       BROWNOUT_DETECTOR_OFF_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // status and clock pin
    input wire logic       CPU_RUN_O,
    input wire logic       SYS_CLK_O,
    input wire logic [2:0] XTAL_MODE_O,
    input wire logic [1:0] SOURCE_KIND_O,
    input wire logic       CLOCK_PIN_O,
    input wire logic       CLOCK_PIN_OE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    reset_quiet_a: assert property (disable iff (1'b0)
        !ARST_N_I |-> !CLOCK_PIN_O && !CPU_RUN_O)
        else $error("outputs active during reset");
    pin_idle_a: assert property (
        !CPU_RUN_O && !$past(CPU_RUN_O) |-> !CLOCK_PIN_O)
        else $error("clock pin toggles while held");
    pin_follow_a: assert property (
        CPU_RUN_O && $past(CPU_RUN_O) && !CLOCK_OUTPUT_FUSE_N_I
        |-> CLOCK_PIN_O == SYS_CLK_O || CLOCK_PIN_O == $past(SYS_CLK_O))
        else $error("clock pin not the divided clock");
    pin_enable_a: assert property (
        $past(ARST_N_I, 2) |-> CLOCK_PIN_OE_O == !CLOCK_OUTPUT_FUSE_N_I)
        else $error("clock pin enable wrong");
    rdata_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data without read");
    trim_rw_a: assert property (
        WR_I && ADDR_I == TRIM_OFFSET ##1 RD_I && ADDR_I == TRIM_OFFSET
        |=> RDATA_O == $past(WDATA_I, 2))
        else $error("trim readback wrong");
    unlock_expire_a: assert property (
        WR_I && ADDR_I == PRESCALE_OFFSET && WDATA_I == 8'h80
        ##1 (!WR_I && !RD_I) [*7] ##1 RD_I && ADDR_I == PRESCALE_OFFSET
        |=> !RDATA_O[UNLOCK_BIT] && RDATA_O[6:4] == 3'h0)
        else $error("unlock bit did not expire");
    src_xtal_a: assert property (
        $past(ARST_N_I, 2) && CLOCK_SOURCE_SELECT_I[3]
        |-> SOURCE_KIND_O == 2'h2 && XTAL_MODE_O == CLOCK_SOURCE_SELECT_I[3:1])
        else $error("crystal mode wrong");
    wake_hold_a: assert property (
        $rose(WAKE_I) && BROWNOUT_DETECTOR_OFF_I && CPU_RUN_O
        |-> ##[1:8] (!CPU_RUN_O) [*8])
        else $error("wake settle missing");
endmodule : clk_ctrl_asserts

// ==== tb/ext_osc.sv ====
// free-running source and watchdog oscillators outside the block
`timescale 1ns/1ps
module ext_osc #(
    parameter real OSC_HALF_NS = 7.0,
    parameter real WDT_HALF_NS = 9.0
) (
    // slow crystal doubles the source period
    input  wire logic slow_i,
    // oscillator levels
    output logic      osc_tick_o,
    output logic      wdt_tick_o
);
    initial begin
        osc_tick_o = 1'b0;
        forever #(slow_i ? 2.0 * OSC_HALF_NS : OSC_HALF_NS)
            osc_tick_o = ~osc_tick_o;
    end
    initial begin
        wdt_tick_o = 1'b0;
        forever #(WDT_HALF_NS) wdt_tick_o = ~wdt_tick_o;
    end
endmodule : ext_osc

// ==== tb/testbench.sv ====
// self-checking bench for the clock control block
`timescale 1ns/1ps
module testbench
    import clk_ctrl_pkg::*;
;
    logic       CLK_I = 1'b0;
    logic       ARST_N_I = 1'b0;
    logic [3:0] CLOCK_SOURCE_SELECT_I = SRC_LFXTAL;
    logic [1:0] STARTUP_TIME_SELECT_I = 2'h0;
    logic       DIVIDE_BY_EIGHT_DEFAULT_N_I = 1'b0;
    logic       CLOCK_OUTPUT_FUSE_N_I = 1'b0;
    logic [7:0] CALIBRATION_I = 8'ha5;
    logic       WAKE_I = 1'b0;
    logic       BROWNOUT_DETECTOR_OFF_I = 1'b0;
    logic [7:0] ADDR_I = 8'h00;
    logic [7:0] WDATA_I = 8'h00;
    logic       WR_I = 1'b0;
    logic       RD_I = 1'b0;
    logic       slow = 1'b0;
    logic       osc_tick;
    logic       wdt_tick;
    logic [7:0] RDATA_O;
    logic       CPU_RUN_O;
    logic       SYS_TICK_O;
    logic       SYS_CLK_O;
    logic [2:0] XTAL_MODE_O;
    logic [1:0] SOURCE_KIND_O;
    logic       CLOCK_PIN_O;
    logic       CLOCK_PIN_OE_O;
    logic [3:0] cur = 4'h3;
    int         mismatches = 0;
    int         compares = 0;
    int         cycles = 0;
    int         n;

    clk_ctrl dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
        .CLOCK_SOURCE_SELECT_I(CLOCK_SOURCE_SELECT_I),
        .STARTUP_TIME_SELECT_I(STARTUP_TIME_SELECT_I),
        .DIVIDE_BY_EIGHT_DEFAULT_N_I(DIVIDE_BY_EIGHT_DEFAULT_N_I),
        .CLOCK_OUTPUT_FUSE_N_I(CLOCK_OUTPUT_FUSE_N_I),
        .CALIBRATION_I(CALIBRATION_I), .OSC_TICK_I(osc_tick),
        .WDT_TICK_I(wdt_tick), .WAKE_I(WAKE_I),
        .BROWNOUT_DETECTOR_OFF_I(BROWNOUT_DETECTOR_OFF_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .CPU_RUN_O(CPU_RUN_O), .SYS_TICK_O(SYS_TICK_O),
        .SYS_CLK_O(SYS_CLK_O), .XTAL_MODE_O(XTAL_MODE_O),
        .SOURCE_KIND_O(SOURCE_KIND_O), .CLOCK_PIN_O(CLOCK_PIN_O),
        .CLOCK_PIN_OE_O(CLOCK_PIN_OE_O));
    ext_osc osc (.slow_i(slow), .osc_tick_o(osc_tick), .wdt_tick_o(wdt_tick));

    initial forever #2 CLK_I = ~CLK_I;

    task automatic end_of_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge CLK_I) begin
        cycles = cycles + 1;
        if (cycles == 80000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    task automatic rng(input int v, input int lo, input int hi);
        compares++;
        if (v < lo || v >= hi) begin
            $display("ERROR %0t count %0d not in %0d..%0d", $time, v, lo, hi);
            mismatches++;
        end
    endtask : rng
    task automatic step;
        @(posedge CLK_I);
        #1;
    endtask : step
    task automatic idle(input int k);
        @(posedge CLK_I);
        WR_I <= 1'b0;
        RD_I <= 1'b0;
        repeat (k - 1) @(posedge CLK_I);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        WR_I <= 1'b1;
        RD_I <= 1'b0;
        ADDR_I <= a;
        WDATA_I <= d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK_I);
        RD_I <= 1'b1;
        WR_I <= 1'b0;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1;
        chk(RDATA_O, exp);
    endtask : rd
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (CPU_RUN_O !== 1'b1 && n < hi) begin
            step();
            n++;
        end
        rng(n, lo, hi);
    endtask : wait_run
    // measure cycles between two system ticks
    task automatic meas(input int exp);
        int hc;
        int pc;
        int eh;
        n = 0;
        while (SYS_TICK_O !== 1'b1 && n < 600) begin
            step();
            n++;
        end
        n = 0;
        hc = 0;
        pc = 0;
        do begin
            step();
            n++;
            hc += (SYS_CLK_O === 1'b1);
            pc += (CLOCK_PIN_O === 1'b1);
        end while (SYS_TICK_O !== 1'b1 && n < 600);
        eh = (exp == 1) ? 1 : exp / 2;
        rng(n, exp, exp + 1);
        rng(hc, eh, eh + 1);
        rng(pc, CLOCK_OUTPUT_FUSE_N_I ? 0 : eh,
            CLOCK_OUTPUT_FUSE_N_I ? 1 : eh + 1);
    endtask : meas
    task automatic boot(input logic [3:0] src, input logic [1:0] startup_time_select,
                        input logic d8n, input logic con, input logic [7:0] cal);
        @(posedge CLK_I);
        ARST_N_I <= 1'b0;
        CLOCK_SOURCE_SELECT_I <= src;
        STARTUP_TIME_SELECT_I <= startup_time_select;
        DIVIDE_BY_EIGHT_DEFAULT_N_I <= d8n;
        CLOCK_OUTPUT_FUSE_N_I <= con;
        CALIBRATION_I <= cal;
        repeat (10) @(posedge CLK_I);
        ARST_N_I <= 1'b1;
        idle(3);
        #1;
    endtask : boot

    initial begin
        boot(SRC_LFXTAL, 2'h0, 1'b0, 1'b0, 8'ha5);
        chk({6'h0, SOURCE_KIND_O}, 8'h01);
        rd(TRIM_OFFSET, 8'ha5);
        rd(PRESCALE_OFFSET, 8'h03);
        wait_run(3000, 20000);
        wr(TRIM_OFFSET, 8'h5a);
        rd(TRIM_OFFSET, 8'h5a);
        rd(8'h10, 8'h00);
        // locked writes, a dirty unlock and an expired unlock are ignored
        wr(PRESCALE_OFFSET, 8'h05);
        rd(PRESCALE_OFFSET, 8'h03);
        wr(PRESCALE_OFFSET, 8'h81);
        wr(PRESCALE_OFFSET, 8'h02);
        rd(PRESCALE_OFFSET, 8'h03);
        wr(PRESCALE_OFFSET, 8'h80);
        idle(7);
        rd(PRESCALE_OFFSET, 8'h03);
        // rewriting the unlock value must not stretch the window
        repeat (5) wr(PRESCALE_OFFSET, 8'h80);
        wr(PRESCALE_OFFSET, 8'h05);
        rd(PRESCALE_OFFSET, 8'h03);
        wr(PRESCALE_OFFSET, 8'h05);
        rd(PRESCALE_OFFSET, 8'h03);
        for (int c = 9; c >= 0; c--) begin
            wr(PRESCALE_OFFSET, 8'h80);
            rd(PRESCALE_OFFSET, {4'h8, cur});
            wr(PRESCALE_OFFSET, 8'(c));
            rd(PRESCALE_OFFSET, 8'(c));
            cur = 4'(c);
            idle(800);
            meas(c > 8 ? 256 : 1 << c);
        end
        @(posedge CLK_I);
        WAKE_I <= 1'b1;
        BROWNOUT_DETECTOR_OFF_I <= 1'b1;
        idle(50);
        #1;
        chk({7'h0, CPU_RUN_O}, 8'h00);
        wait_run(14000, 16000);
        @(posedge CLK_I);
        WAKE_I <= 1'b0;
        slow = 1'b1;
        boot(4'hc, 2'h2, 1'b1, 1'b1, 8'h3c);
        chk({5'h0, XTAL_MODE_O}, 8'h06);
        chk({7'h0, CLOCK_PIN_OE_O}, 8'h00);
        rd(TRIM_OFFSET, 8'h3c);
        rd(PRESCALE_OFFSET, 8'h00);
        wait_run(6500, 20000);
        meas(1);
        chk({7'h0, CLOCK_PIN_O}, 8'h00);
        slow = 1'b0;
        boot(SRC_RC8M, 2'h2, 1'b0, 1'b0, 8'h77);
        chk({6'h0, SOURCE_KIND_O}, 8'h00);
        chk({7'h0, CLOCK_PIN_OE_O}, 8'h01);
        rd(PRESCALE_OFFSET, 8'h03);
        end_of_test();
    end
endmodule : testbench

bind clk_ctrl clk_ctrl_asserts u_asserts (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .CLOCK_SOURCE_SELECT_I(CLOCK_SOURCE_SELECT_I),
    .CLOCK_OUTPUT_FUSE_N_I(CLOCK_OUTPUT_FUSE_N_I), .WAKE_I(WAKE_I),
    .BROWNOUT_DETECTOR_OFF_I(BROWNOUT_DETECTOR_OFF_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CPU_RUN_O(CPU_RUN_O), .SYS_CLK_O(SYS_CLK_O), .XTAL_MODE_O(XTAL_MODE_O),
    .SOURCE_KIND_O(SOURCE_KIND_O), .CLOCK_PIN_O(CLOCK_PIN_O),
    .CLOCK_PIN_OE_O(CLOCK_PIN_OE_O));
